// >>> core/src_relay.sv
// Status relay controller: fault, manual and list relay modes.
//
// Function
// R01: Error-only selection: system error energizes relay immediately
// R02: CV-to-CC selection: error or persisting CC energizes
// R03: CC-to-CV selection: error or persisting CV energizes
// R04: Transition energizes only after full continuous delay
// R05: Delay is integer seconds plus half; zero refused
// R06: Delay resets to one second
// R07: Transition relay releases on return or output off
// R08: Manual mode drives confirmed state at once
// R09: Manual state not kept; relay off after power-up
// R10: List mode follows remote list commands only
// R11: Fault mode is the reset mode
// R12: Security reset restores fault mode, error-only
// R13: Present relay state is readable for display
// R14: Leaving new mode early restarts delay timer
// R15: Timer counts half-second ticks against setting
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
module src_relay #(
	parameter int unsigned TICK_CYCLES = 32'(src_pkg::TICK_CYCLES)
) (
	input  wire logic                      clk_sys,
	input  wire logic                      reset,
	// Register port
	input  wire logic [src_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]               reg_wdata,
	input  wire logic                      reg_wr,
	input  wire logic                      reg_rd,
	output logic [31:0]                    reg_rdata,
	// Supply state
	input  wire logic                      cv_active,
	input  wire logic                      cc_active,
	input  wire logic                      system_error,
	input  wire logic                      output_enabled,
	// Remote list sequence command
	input  wire logic                      list_relay_valid,
	input  wire logic                      list_relay_on,
	// Relay coil and interrupt
	output logic                           relay_on,
	output logic                           irq
);
	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	wire wr_ctrl  = reg_wr && (reg_addr == src_pkg::REG_CTRL);
	wire wr_delay = reg_wr && (reg_addr == src_pkg::REG_DELAY);
	wire wr_man   = reg_wr && (reg_addr == src_pkg::REG_MANUAL);
	wire wr_stat  = reg_wr && (reg_addr == src_pkg::REG_IRQ_STAT);
	wire wr_mask  = reg_wr && (reg_addr == src_pkg::REG_IRQ_MASK);
	wire wr_cmd   = reg_wr && (reg_addr == src_pkg::REG_COMMAND);

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	src_pkg::src_mode_t mode_q;      // Relay control mode
	src_pkg::src_sel_t  sel_q;       // Fault-mode selection
	logic [8:0]         delay_q;     // {integer seconds, half flag}
	logic               manual_q;    // Manual relay state
	logic               list_q;      // Last list command state
	logic [src_pkg::IRQ_W-1:0] irq_stat_q; // Sticky events
	logic [src_pkg::IRQ_W-1:0] irq_mask_q; // Event enables
	logic               relay_q;     // Relay drive
	logic [31:0]        rdata_q;     // Read data, one cycle late

	// Decoded write fields
	wire [1:0] wmode = reg_wdata[src_pkg::CTRL_MODE_LSB +: 2];
	wire [1:0] wsel  = reg_wdata[src_pkg::CTRL_SEL_LSB +: 2];
	wire [7:0] wint  = reg_wdata[src_pkg::DLY_INT_LSB +: src_pkg::DLY_INT_W];
	wire       whalf = reg_wdata[src_pkg::DLY_HALF_BIT];
	wire [8:0] wdly  = {wint, whalf};
	wire       sec_reset = wr_cmd && reg_wdata[src_pkg::CMD_SEC_BIT];

	// Zero, or above 128.0 s, is refused and the old setting kept
	wire dly_bad = (wdly == src_pkg::DLY_ZERO) ||
	               (wint > src_pkg::DLY_INT_MAX) ||
	               ((wint == src_pkg::DLY_INT_MAX) && whalf); // [R05]
	wire mode_ok = (wmode != 2'h3);
	wire sel_ok  = (wsel != 2'h3);

	// Control register: security reset outranks a plain write
	always_ff @(posedge clk_sys) begin
		if (reset || sec_reset) begin
			mode_q <= src_pkg::SRC_MODE_FAULT;      // [R11] [R12]
			sel_q  <= src_pkg::SRC_SEL_ERROR_ONLY;  // [R12]
		end else if (wr_ctrl && mode_ok && sel_ok) begin
			mode_q <= src_pkg::src_mode_t'(wmode);
			sel_q  <= src_pkg::src_sel_t'(wsel);
		end
	end

	// Delay setting
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			delay_q <= src_pkg::DLY_RESET; // [R06]
		end else if (wr_delay && !dly_bad) begin
			delay_q <= wdly; // [R05]
		end
	end

	// Manual and list states; neither survives a reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			manual_q <= 1'b0; // [R09]
			list_q   <= 1'b0;
		end else begin
			if (wr_man) begin
				manual_q <= reg_wdata[0]; // [R08]
			end
			if (list_relay_valid) begin
				list_q <= list_relay_on; // [R10]
			end
		end
	end

	// ------------------------------------------------------------------
	// Transition detection and timing
	// ------------------------------------------------------------------
	// Armed while the supply sits in the selected target regime and
	// the output is on; output off or return disarms and clears
	wire in_target = (sel_q == src_pkg::SRC_SEL_CV_TO_CC) ? cc_active :
	                 (sel_q == src_pkg::SRC_SEL_CC_TO_CV) ? cv_active :
	                 1'b0;
	wire armed = in_target && output_enabled &&
	             (mode_q == src_pkg::SRC_MODE_FAULT); // [R14] [R07]
	logic tick;
	logic expired;

	// Prescaler restarts with each arming so the count is exact
	src_tick #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.clk_sys (clk_sys),
		.reset   (reset),
		.restart (!armed),
		.tick    (tick)
	); // [R15]

	// Persistence counter against stored delay
	src_delay u_delay (
		.clk_sys (clk_sys),
		.reset   (reset),
		.armed   (armed),
		.tick    (tick),
		.limit   (delay_q),
		.expired (expired)
	); // [R04] [R15]

	// ------------------------------------------------------------------
	// Relay selection
	// ------------------------------------------------------------------
	// Error path needs no delay in every fault selection
	wire fault_relay = system_error ||
	                   ((sel_q != src_pkg::SRC_SEL_ERROR_ONLY) &&
	                    expired); // [R01] [R02] [R03] [R07]
	logic relay_d;
	always_comb begin
		unique case (mode_q)
			src_pkg::SRC_MODE_FAULT:  relay_d = fault_relay;
			src_pkg::SRC_MODE_MANUAL: relay_d = manual_q; // [R08]
			src_pkg::SRC_MODE_LIST:   relay_d = list_q;   // [R10]
			default:                  relay_d = 1'b0;
		endcase
	end

	// Relay drive register; off after reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			relay_q <= 1'b0; // [R09]
		end else begin
			relay_q <= relay_d;
		end
	end
	assign relay_on = relay_q;

	// ------------------------------------------------------------------
	// Interrupt events
	// ------------------------------------------------------------------
	logic [src_pkg::IRQ_W-1:0] ev;
	always_comb begin
		ev = '0;
		ev[src_pkg::IRQ_ON_BIT]  = relay_d && !relay_q;
		ev[src_pkg::IRQ_OFF_BIT] = !relay_d && relay_q;
		ev[src_pkg::IRQ_ERR_BIT] = system_error;
		ev[src_pkg::IRQ_REJ_BIT] = wr_delay && dly_bad;
	end
	wire [src_pkg::IRQ_W-1:0] clr =
		wr_stat ? reg_wdata[src_pkg::IRQ_W-1:0] : '0;

	// Sticky status; a new event wins over a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_stat_q <= '0;
			irq_mask_q <= '0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
			if (wr_mask) begin
				irq_mask_q <= reg_wdata[src_pkg::IRQ_W-1:0];
			end
		end
	end
	assign irq = |(irq_stat_q & irq_mask_q);

	// ------------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------------
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		unique case (reg_addr)
			src_pkg::REG_CTRL:
				rmux[3:0] = {sel_q, mode_q};
			src_pkg::REG_DELAY:
				rmux[8:0] = delay_q;
			src_pkg::REG_MANUAL:
				rmux[0] = manual_q;
			src_pkg::REG_STATUS:
				rmux[4:0] = {output_enabled, system_error, cc_active,
				             cv_active, relay_q}; // [R13]
			src_pkg::REG_IRQ_STAT:
				rmux[src_pkg::IRQ_W-1:0] = irq_stat_q;
			src_pkg::REG_IRQ_MASK:
				rmux[src_pkg::IRQ_W-1:0] = irq_mask_q;
			default:
				rmux = 32'h0; // Unmapped reads zero
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= reg_rd ? rmux : 32'h0;
		end
	end
	assign reg_rdata = rdata_q;
endmodule : src_relay

// >>> shared/src_pkg.sv
// Constants and types shared by the status relay controller.
package src_pkg;
	// ------------------------------------------------------------------
	// Relay control modes and fault selections
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_MODE_FAULT,
		SRC_MODE_MANUAL,
		SRC_MODE_LIST
	} src_mode_t;

	typedef enum logic [1:0] {
		SRC_SEL_ERROR_ONLY,
		SRC_SEL_CV_TO_CC,
		SRC_SEL_CC_TO_CV
	} src_sel_t;

	// ------------------------------------------------------------------
	// Register map (word addresses on the plain port)
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 4;
	localparam logic [3:0]  REG_CTRL      = 4'h0; // Mode, selection
	localparam logic [3:0]  REG_DELAY     = 4'h1; // Delay setting
	localparam logic [3:0]  REG_MANUAL    = 4'h2; // Manual relay state
	localparam logic [3:0]  REG_STATUS    = 4'h3; // Relay and inputs
	localparam logic [3:0]  REG_IRQ_STAT  = 4'h4; // Sticky events, W1C
	localparam logic [3:0]  REG_IRQ_MASK  = 4'h5; // Event enables
	localparam logic [3:0]  REG_COMMAND   = 4'h6; // Security reset

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_SEL_LSB   = 2;
	localparam int DLY_HALF_BIT   = 0;
	localparam int DLY_INT_LSB    = 1;
	localparam int DLY_INT_W      = 8;
	localparam int CMD_SEC_BIT    = 0;
	localparam int IRQ_W          = 4;
	localparam int IRQ_ON_BIT     = 0; // Relay energized
	localparam int IRQ_OFF_BIT    = 1; // Relay released
	localparam int IRQ_ERR_BIT    = 2; // System error seen
	localparam int IRQ_REJ_BIT    = 3; // Delay write refused

	// ------------------------------------------------------------------
	// Delay limits and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0]  DLY_INT_MAX   = 8'h80; // 128 s
	localparam logic [8:0]  DLY_RESET     = 9'h002; // 1.0 s
	localparam logic [8:0]  DLY_ZERO      = 9'h000;

	// ------------------------------------------------------------------
	// Timing: half-second tick at the system clock rate
	// ------------------------------------------------------------------
	localparam longint CLK_HZ      = 50000000;
	localparam longint TICK_MS     = 500;
	localparam longint TICK_CYCLES = CLK_HZ * TICK_MS / 1000;
endpackage : src_pkg

// >>> core/src_tick.sv
// Half-second tick generator for the transition delay timer.
`timescale 1ns/100ps
module src_tick #(
	parameter int unsigned TICK_CYCLES = 32'(src_pkg::TICK_CYCLES)
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic restart,
	output logic      tick
);
	// ------------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------------
	logic [31:0] cnt_q; // Cycles into the current half second
	logic [31:0] cnt_d;
	wire         last = (cnt_q == TICK_CYCLES - 1);

	// Restart aligns the first tick to a full period after the event
	assign cnt_d = (restart || last) ? 32'h0 : cnt_q + 32'h1;
	assign tick  = last && !restart;

	// Count register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : src_tick

// >>> core/src_delay.sv
// Transition persistence timer counting half-second ticks.
`timescale 1ns/100ps
module src_delay (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       armed,
	input  wire logic       tick,
	input  wire logic [8:0] limit,
	output logic            expired
);
	// ------------------------------------------------------------------
	// Half-second counter
	// ------------------------------------------------------------------
	logic [8:0] cnt_q; // Half seconds spent in the new mode
	logic [8:0] cnt_d;
	wire        full = (cnt_q >= limit);

	// Leaving the new mode clears the count, so excursions never add up
	assign cnt_d   = !armed ? 9'h000 :
	                 (tick && !full) ? cnt_q + 9'h001 : cnt_q;
	assign expired = armed && full && (limit != src_pkg::DLY_ZERO);

	// Count register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_q <= 9'h000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : src_delay

// >>> verif/src_load_model.sv
// Model of the equipment wired to the relay contacts.
`timescale 1ns/100ps
module src_load_model (
	input  wire logic clk_sys,
	input  wire logic relay_on,
	output logic      contact_closed
);
	// Armature settles one cycle after the coil changes
	always_ff @(posedge clk_sys) begin
		contact_closed <= relay_on;
	end
endmodule : src_load_model

// >>> verif/src_relay_asserts.sv
// Port-level assertions for the status relay controller.
`timescale 1ns/100ps
module src_relay_asserts #(
	parameter int unsigned TICK_CYCLES = 4
) (
	input wire logic                       clk_sys,
	input wire logic                       reset,
	input wire logic [src_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0]                reg_wdata,
	input wire logic                       reg_wr,
	input wire logic                       reg_rd,
	input wire logic [31:0]                reg_rdata,
	input wire logic                       cv_active,
	input wire logic                       cc_active,
	input wire logic                       system_error,
	input wire logic                       output_enabled,
	input wire logic                       list_relay_valid,
	input wire logic                       list_relay_on,
	input wire logic                       relay_on,
	input wire logic                       irq
);
	src_pkg::src_mode_t mode_q;   // Mode as software last set it
	src_pkg::src_sel_t  sel_q;    // Selection as last set
	logic [8:0]         dly_q;    // Last accepted delay
	int unsigned        arm_n_q;  // Cycles armed in a row
	logic               man_bit;  // Manual state being written
	logic               ctl_ok;   // Legal control write
	logic               fault_mode;      // Fault mode active
	logic               err_only; // Fault mode, error-only
	logic               armed;    // Transition condition held
	assign man_bit  = reg_wdata[0];
	assign ctl_ok   = reg_wr && reg_addr == src_pkg::REG_CTRL
		&& reg_wdata[1:0] != 2'h3 && reg_wdata[3:2] != 2'h3;
	assign fault_mode      = mode_q == src_pkg::SRC_MODE_FAULT;
	assign err_only = fault_mode && sel_q == src_pkg::SRC_SEL_ERROR_ONLY;
	assign armed    = fault_mode && output_enabled
		&& (sel_q == src_pkg::SRC_SEL_CV_TO_CC ? cc_active
		: sel_q == src_pkg::SRC_SEL_CC_TO_CV && cv_active);
	// Mirror of the settings; a refused delay leaves the old one
	always_ff @(posedge clk_sys) begin
		if (reset || (reg_wr && reg_addr == src_pkg::REG_COMMAND
			&& reg_wdata[0])) begin
			mode_q <= src_pkg::SRC_MODE_FAULT;
			sel_q  <= src_pkg::SRC_SEL_ERROR_ONLY;
		end else if (ctl_ok) begin
			mode_q <= src_pkg::src_mode_t'(reg_wdata[1:0]);
			sel_q  <= src_pkg::src_sel_t'(reg_wdata[3:2]);
		end
		if (reset) begin
			dly_q <= src_pkg::DLY_RESET;
		end else if (reg_wr && reg_addr == src_pkg::REG_DELAY
			&& reg_wdata[8:0] != 9'h0
			&& reg_wdata[8:0] <= {src_pkg::DLY_INT_MAX, 1'b0}) begin
			dly_q <= reg_wdata[8:0];
		end
		arm_n_q <= (armed && !reset) ? arm_n_q + 32'h1 : 32'h0;
	end
	a_rdata_idle: assert property (@(posedge clk_sys) disable iff (reset)
		!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
	a_power_off: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> !relay_on) else $error("relay on after reset");
	a_error_sets: assert property (@(posedge clk_sys) disable iff (reset)
		fault_mode && system_error |=> relay_on) else $error("error missed");
	a_error_follow: assert property (@(posedge clk_sys) disable iff (reset)
		err_only && $past(err_only) && $past(err_only, 3)
		|-> relay_on == $past(system_error)) else $error("relay not error");
	a_manual_set: assert property (@(posedge clk_sys) disable iff (reset)
		reg_wr && reg_addr == src_pkg::REG_MANUAL
		&& mode_q == src_pkg::SRC_MODE_MANUAL
		|-> ##2 relay_on == $past(man_bit, 2)) else $error("manual missed");
	a_list_only: assert property (@(posedge clk_sys) disable iff (reset)
		$past(mode_q) == src_pkg::SRC_MODE_LIST
		&& $past(mode_q, 3) == src_pkg::SRC_MODE_LIST && $changed(relay_on)
		|-> $past(list_relay_valid) || $past(list_relay_valid, 2))
		else $error("list relay moved alone");
	a_disarm_off: assert property (@(posedge clk_sys) disable iff (reset)
		(fault_mode && !armed && !system_error) [*2] |=> !relay_on)
		else $error("relay held after disarm");
	a_trans_wait: assert property (@(posedge clk_sys) disable iff (reset)
		$past(mode_q) == src_pkg::SRC_MODE_FAULT && $rose(relay_on)
		&& !$past(system_error) |-> arm_n_q >= dly_q * TICK_CYCLES)
		else $error("relay before delay");
	a_trans_fire: assert property (@(posedge clk_sys) disable iff (reset)
		arm_n_q == dly_q * TICK_CYCLES + 6 |-> relay_on)
		else $error("relay late after delay");
endmodule : src_relay_asserts
bind src_relay src_relay_asserts #(.TICK_CYCLES(TICK_CYCLES))
	src_relay_asserts_inst (.clk_sys, .reset, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .cv_active, .cc_active, .system_error,
	.output_enabled, .list_relay_valid, .list_relay_on, .relay_on, .irq);

// >>> verif/test_src_relay.sv
// Self-checking bench for the status relay controller.
`timescale 1ns/100ps
module test_src_relay;
	localparam int unsigned TC = 4; // Short tick keeps delays brief
	logic        clk_sys = 1'b0;
	logic        reset = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        cv_active = 1'b1;
	logic        cc_active = 1'b0;
	logic        system_error = 1'b0;
	logic        output_enabled = 1'b0;
	logic        list_relay_valid = 1'b0;
	logic        list_relay_on = 1'b0;
	logic        relay_on;
	logic        irq;
	logic        contact;   // Far-side contact state
	int          n_errors = 0;
	int          cmp_count = 0;
	int          ticks = 0;
	always #10 clk_sys = ~clk_sys;
	src_relay #(.TICK_CYCLES(TC)) src_relay_inst (.clk_sys, .reset,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cv_active,
		.cc_active, .system_error, .output_enabled, .list_relay_valid,
		.list_relay_on, .relay_on, .irq);
	src_load_model src_load_model_inst (.clk_sys, .relay_on,
		.contact_closed(contact));
	// Cut a hang short; the whole run needs well under 2000 cycles
	always @(posedge clk_sys) begin
		ticks <= ticks + 1;
		if (ticks == 5000) begin
			n_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic chk_bit(input string nm, input logic e, g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : chk_bit
	// Sample 1 ns after the n-th edge, once its updates have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		cyc(1);
		reg_rd <= 1'b0;
		chk("rdata", e, reg_rdata);
	endtask : rd
	task automatic drive(input logic cv, cc, er, oe);
		@(posedge clk_sys);
		cv_active      <= cv;
		cc_active      <= cc;
		system_error   <= er;
		output_enabled <= oe;
		#1;
	endtask : drive
	task automatic lpulse(input logic v);
		@(posedge clk_sys);
		list_relay_valid <= 1'b1;
		list_relay_on    <= v;
		cyc(1);
		list_relay_valid <= 1'b0;
	endtask : lpulse
	task automatic wait_rly(output int n);
		n = 0;
		while (relay_on !== 1'b1 && n < 600) begin
			cyc(1);
			n++;
		end
	endtask : wait_rly
	task automatic t_defaults();
		chk_bit("relay", 1'b0, relay_on);
		rd(src_pkg::REG_CTRL, 32'h0);
		rd(src_pkg::REG_DELAY, {23'h0, src_pkg::DLY_RESET});
		rd(src_pkg::REG_IRQ_MASK, 32'h0);
		rd(src_pkg::REG_STATUS, 32'h2);
		rd(4'hF, 32'h0);
		$display("test defaults done");
	endtask : t_defaults
	task automatic t_error();
		drive(1'b1, 1'b0, 1'b1, 1'b0);
		cyc(2);
		chk_bit("relay", 1'b1, relay_on);
		rd(src_pkg::REG_STATUS, 32'hB);
		chk_bit("irq", 1'b0, irq);
		wr(src_pkg::REG_IRQ_MASK, 32'h4);
		chk_bit("irq", 1'b1, irq);
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(2);
		chk_bit("relay", 1'b0, relay_on);
		rd(src_pkg::REG_IRQ_STAT, 32'h7);
		wr(src_pkg::REG_IRQ_STAT, 32'hF);
		rd(src_pkg::REG_IRQ_STAT, 32'h0);
		chk_bit("irq", 1'b0, irq);
		wr(src_pkg::REG_IRQ_MASK, 32'h0);
		$display("test error done");
	endtask : t_error
	task automatic t_reject();
		wr(src_pkg::REG_DELAY, 32'h0);
		rd(src_pkg::REG_DELAY, {23'h0, src_pkg::DLY_RESET});
		wr(src_pkg::REG_DELAY, 32'h101);
		rd(src_pkg::REG_DELAY, {23'h0, src_pkg::DLY_RESET});
		rd(src_pkg::REG_IRQ_STAT, 32'h8);
		wr(src_pkg::REG_DELAY, 32'h100);
		rd(src_pkg::REG_DELAY, 32'h100);
		wr(src_pkg::REG_IRQ_STAT, 32'hF);
		$display("test reject done");
	endtask : t_reject
	// Excursion just short of the delay, then a full run in new mode
	task automatic t_trans(input logic [31:0] ctl, dly, input logic to_cc);
		int n;
		int lim;
		lim = int'(dly) * TC;
		wr(src_pkg::REG_DELAY, dly);
		wr(src_pkg::REG_CTRL, ctl);
		drive(to_cc, !to_cc, 1'b0, 1'b1);
		drive(!to_cc, to_cc, 1'b0, 1'b1);
		cyc(lim - 2);
		chk_bit("early", 1'b0, relay_on);
		drive(to_cc, !to_cc, 1'b0, 1'b1);
		cyc(2);
		drive(!to_cc, to_cc, 1'b0, 1'b1);
		wait_rly(n);
		chk_bit("delay", 1'b1, n >= lim - 1 && n <= lim + 6);
		cyc(8);
		drive(to_cc, !to_cc, 1'b0, 1'b1);
		cyc(3);
		chk_bit("back", 1'b0, relay_on);
		drive(!to_cc, to_cc, 1'b0, 1'b1);
		wait_rly(n);
		drive(!to_cc, to_cc, 1'b0, 1'b0);
		cyc(3);
		chk_bit("outoff", 1'b0, relay_on);
		drive(to_cc, !to_cc, 1'b1, 1'b0);
		cyc(2);
		chk_bit("err", 1'b1, relay_on);
		drive(to_cc, !to_cc, 1'b0, 1'b0);
		cyc(3);
		$display("test transition done");
	endtask : t_trans
	task automatic t_manual();
		wr(src_pkg::REG_CTRL, 32'h1);
		wr(src_pkg::REG_MANUAL, 32'h1);
		cyc(1);
		chk_bit("relay", 1'b1, relay_on);
		cyc(1);
		chk_bit("contact", 1'b1, contact);
		drive(1'b1, 1'b0, 1'b1, 1'b0);
		wr(src_pkg::REG_MANUAL, 32'h0);
		cyc(1);
		chk_bit("relay", 1'b0, relay_on);
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		wr(src_pkg::REG_MANUAL, 32'h1);
		@(posedge clk_sys);
		reset <= 1'b1;
		cyc(2);
		chk_bit("relay", 1'b0, relay_on);
		@(posedge clk_sys);
		reset <= 1'b0;
		rd(src_pkg::REG_CTRL, 32'h0);
		rd(src_pkg::REG_MANUAL, 32'h0);
		$display("test manual done");
	endtask : t_manual
	task automatic t_list();
		wr(src_pkg::REG_CTRL, 32'h2);
		cyc(3);
		lpulse(1'b1);
		cyc(2);
		chk_bit("relay", 1'b1, relay_on);
		drive(1'b1, 1'b0, 1'b1, 1'b0);
		wr(src_pkg::REG_MANUAL, 32'h0);
		cyc(2);
		chk_bit("relay", 1'b1, relay_on);
		lpulse(1'b0);
		cyc(2);
		chk_bit("relay", 1'b0, relay_on);
		drive(1'b1, 1'b0, 1'b0, 1'b0);
		$display("test list done");
	endtask : t_list
	task automatic t_secure();
		wr(src_pkg::REG_CTRL, 32'h5);
		wr(src_pkg::REG_CTRL, 32'hE);
		rd(src_pkg::REG_CTRL, 32'h5);
		wr(src_pkg::REG_COMMAND, 32'h1);
		rd(src_pkg::REG_CTRL, 32'h0);
		$display("test secure done");
	endtask : t_secure
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		t_defaults();
		t_error();
		t_reject();
		t_trans(32'h4, 32'h2, 1'b1);
		t_trans(32'h8, 32'h3, 1'b0);
		t_manual();
		t_list();
		t_secure();
		complete_run();
	end
endmodule : test_src_relay
